//--- verilog/hpsm_pkg.sv
// Package for the host port signal mux: configuration field layout,
// reset values and pin indices.
// Assumes a single core clock domain; nothing here is clocked.
package hpsm_pkg;

  // ==========================================================================
  // Port configuration word layout
  // ==========================================================================
  localparam int CFG_W           = 16;
  localparam int CFG_FN_SEL_BIT  = 0;   // 1: host function, 0: gpio
  localparam int CFG_MUXED_BIT   = 1;   // 1: multiplexed address/data bus
  localparam int CFG_DUAL_DS_BIT = 2;   // 1: separate read and write strobes
  localparam int CFG_SEL_POL_BIT = 3;   // 1: port select active high
  localparam int CFG_ALS_POL_BIT = 4;   // 1: address strobe active high
  localparam int CFG_DS_POL_BIT  = 5;   // 1: data strobes active high
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ==========================================================================
  // Pin numbering of the 16 port pins
  // ==========================================================================
  localparam int NPINS   = 16;
  localparam int PIN_A0  = 8;   // Address 0, or address strobe
  localparam int PIN_A1  = 9;   // Address 1, or address 8
  localparam int PIN_A2  = 10;  // Address 2, or address 9
  localparam int PIN_RW  = 11;  // Read/write, or read strobe
  localparam int PIN_WS  = 12;  // Data strobe, or write strobe
  localparam int PIN_SEL = 13;  // Port select, or address 10
  localparam logic [15:0] DIR_RESET = 16'h0000;

  // Mode of the port as decoded from the configuration word
  typedef enum logic [1:0] {
    HPSM_GPIO  = 2'b00,
    HPSM_PLAIN = 2'b01,
    HPSM_MUXED = 2'b11
  } hpsm_mode_t;

endpackage

//--- verilog/hpsm_pin_if.sv
// Interface carrying the synchronised pin levels between the top module
// and its input synchroniser.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface hpsm_pin_if;
  logic [15:0] raw;   // Pin levels straight from the pads
  logic [15:0] sync;  // Pin levels after two flip-flops
  modport sync_end (input raw, output sync);
  modport user_end (output raw, input sync);
endinterface
`default_nettype wire

//--- verilog/hpsm_sync.sv
// Two-stage synchroniser for all port pin inputs.
// Assumes the pins are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module hpsm_sync (
  input  wire logic   clk,   // Core clock
  input  wire logic   rst,   // Asynchronous reset, active high
  hpsm_pin_if.sync_end pins  // Raw pins in, synchronised pins out
);
  logic [15:0] meta_q;
  logic [15:0] meta_d;
  logic [15:0] sync_q;
  logic [15:0] sync_d;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  always_comb begin
    meta_d = pins.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins.sync = sync_q;
endmodule
`default_nettype wire

//--- verilog/hpsm_top.sv
// Host port signal mux: assigns the 16 port pins to host bus or gpio roles
// from the port configuration word, and presents decoded host bus signals.
// Assumes configuration, direction and stop inputs come from core logic on
// REF_CLK; pins are asynchronous and are synchronised before use.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - All pin roles follow the 16-bit configuration word.
// - Plain host bus: pins 0 to 7 are the bidirectional data bus.
// - Muxed host bus: pins 0 to 7 carry low address byte and data.
// - Gpio mode: every pin direction is set by its own direction bit.
// - Plain host bus: three pins are host address bits 0, 1, 2.
// - Muxed bus: address 1, 2 and select pins become address 8, 9, 10.
// - Muxed bus: one pin is the address strobe, polarity set, low by default.
// - Plain bus: one pin is port select, polarity set, low by default.
// - Single strobe: one pin is the read/write direction input.
// - Dual strobe: same pin is read strobe, polarity set, low by default.
// - Companion pin: write or data strobe, polarity set, low by default.
// - Stop state: inputs ignored, driven pins released, configuration frozen.
module hpsm_top #(
  parameter int CFG_BITS = 16  // Width of the configuration word
) (
  input  wire logic        REF_CLK,       // Core clock, 125 MHz
  input  wire logic        RESET,         // Asynchronous reset, active high
  input  wire logic [15:0] PORT_CFG,      // Port configuration word
  input  wire logic        PORT_CFG_WR,   // Load strobe for PORT_CFG
  input  wire logic [15:0] GPIO_DIR,      // Per-pin direction, 1 = output
  input  wire logic        GPIO_DIR_WR,   // Load strobe for GPIO_DIR
  input  wire logic [15:0] GPIO_OUT,      // Gpio output levels
  input  wire logic        STOP_STATE,    // Core in stop state
  input  wire logic [7:0]  HOST_RD_DATA,  // Data the device returns to host
  input  wire logic        HOST_RD_EN,    // Device drives data lines
  input  wire logic [15:0] PIN_IN,        // Pad input levels
  output logic      [15:0] PIN_OUT,       // Pad output levels
  output logic      [15:0] PIN_OE_N,      // Pad enables, low = driving
  output logic      [15:0] GPIO_IN,       // Synchronised gpio inputs
  output logic      [7:0]  HOST_DATA_IN,  // Data or low address from host
  output logic      [10:0] HOST_ADDR,     // Host address bits 0-2 and 8-10
  output logic             HOST_SEL,      // Port select, true-high
  output logic             HOST_ALS,      // Address strobe, true-high
  output logic             HOST_RNW,      // Read/write, 1 = read
  output logic             HOST_RD_STB,   // Read strobe, true-high
  output logic             HOST_WR_STB,   // Write strobe, true-high
  output logic             HOST_DS,       // Single data strobe, true-high
  output logic [1:0]       PORT_MODE      // Decoded mode of the port
);
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic [15:0] dir_q;
  logic [15:0] dir_d;
  logic        live_q;
  logic        live_d;
  logic [15:0] oe_n_q;
  logic [15:0] oe_n_d;
  logic [15:0] out_q;
  logic [15:0] out_d;
  logic [15:0] gin_q;
  logic [15:0] gin_d;
  logic [7:0]  hdat_q;
  logic [7:0]  hdat_d;
  logic [10:0] addr_q;
  logic [10:0] addr_d;
  logic [5:0]  ctl_q;
  logic [5:0]  ctl_d;
  logic [15:0] pin_s;
  hpsm_pkg::hpsm_mode_t mode;
  logic        dual_ds;
  logic        host_fn;
  logic        sel_pol;
  logic        als_pol;
  logic        ds_pol;

  hpsm_pin_if pins ();

  // Pin synchroniser
  assign pins.raw = PIN_IN;
  assign pin_s    = pins.sync;

  hpsm_sync u_sync (
    .clk  (REF_CLK),
    .rst  (RESET),
    .pins (pins.sync_end)
  );

  // Decodes the port mode from a configuration word
  function automatic hpsm_pkg::hpsm_mode_t mode_of(input logic [15:0] c);
    if (!c[hpsm_pkg::CFG_FN_SEL_BIT])
      return hpsm_pkg::HPSM_GPIO;
    else if (c[hpsm_pkg::CFG_MUXED_BIT])
      return hpsm_pkg::HPSM_MUXED;
    else
      return hpsm_pkg::HPSM_PLAIN;
  endfunction

  // ==========================================================================
  // Configuration state
  // ==========================================================================
  // Configuration frozen in stop state; port goes live on first write
  always_comb begin
    cfg_d  = cfg_q;
    dir_d  = dir_q;
    live_d = live_q;
    if (!STOP_STATE) begin
      if (PORT_CFG_WR) begin
        cfg_d  = PORT_CFG;
        live_d = 1'b1;
      end
      if (GPIO_DIR_WR)
        dir_d = GPIO_DIR;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_q  <= hpsm_pkg::CFG_RESET;
      dir_q  <= hpsm_pkg::DIR_RESET;
      live_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      dir_q  <= dir_d;
      live_q <= live_d;
    end
  end

  always_comb begin
    mode    = mode_of(cfg_q);
    host_fn = (mode != hpsm_pkg::HPSM_GPIO);
    dual_ds = cfg_q[hpsm_pkg::CFG_DUAL_DS_BIT];
    sel_pol = cfg_q[hpsm_pkg::CFG_SEL_POL_BIT];
    als_pol = cfg_q[hpsm_pkg::CFG_ALS_POL_BIT];
    ds_pol  = cfg_q[hpsm_pkg::CFG_DS_POL_BIT];
  end

  // ==========================================================================
  // Pad drive
  // ==========================================================================
  // Enables and levels; stop state releases everything driven
  always_comb begin
    oe_n_d = 16'hffff;
    out_d  = 16'h0000;
    if (live_q && !STOP_STATE) begin
      if (!host_fn) begin
        oe_n_d = ~dir_q;
        out_d  = GPIO_OUT & dir_q;
      end else if (HOST_RD_EN) begin
        oe_n_d[7:0] = 8'h00;
        out_d[7:0]  = HOST_RD_DATA;
      end
    end
  end

  // ==========================================================================
  // Input decode
  // ==========================================================================
  // Inputs held at last value while ignored; polarity turned to true-high
  always_comb begin
    gin_d  = gin_q;
    hdat_d = hdat_q;
    addr_d = addr_q;
    ctl_d  = ctl_q;
    if (live_q && !STOP_STATE) begin
      if (!host_fn) begin
        gin_d = pin_s & ~dir_q;
        ctl_d = 6'h00;
      end else begin
        hdat_d = pin_s[7:0];
        addr_d = 11'h000;
        ctl_d  = 6'h00;
        if (mode == hpsm_pkg::HPSM_MUXED) begin
          addr_d[8]  = pin_s[hpsm_pkg::PIN_A1];
          addr_d[9]  = pin_s[hpsm_pkg::PIN_A2];
          addr_d[10] = pin_s[hpsm_pkg::PIN_SEL];
          ctl_d[1]   = pin_s[hpsm_pkg::PIN_A0] ~^ als_pol;
          ctl_d[0]   = 1'b1;
        end else begin
          addr_d[2:0] = {pin_s[hpsm_pkg::PIN_A2],
                         pin_s[hpsm_pkg::PIN_A1],
                         pin_s[hpsm_pkg::PIN_A0]};
          ctl_d[0] = pin_s[hpsm_pkg::PIN_SEL] ~^ sel_pol;
        end
        if (dual_ds) begin
          ctl_d[3] = pin_s[hpsm_pkg::PIN_RW] ~^ ds_pol;
          ctl_d[4] = pin_s[hpsm_pkg::PIN_WS] ~^ ds_pol;
        end else begin
          ctl_d[2] = pin_s[hpsm_pkg::PIN_RW];
          ctl_d[5] = pin_s[hpsm_pkg::PIN_WS] ~^ ds_pol;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      oe_n_q <= 16'hffff;
      out_q  <= 16'h0000;
      gin_q  <= 16'h0000;
      hdat_q <= 8'h00;
      addr_q <= 11'h000;
      ctl_q  <= 6'h00;
    end else begin
      oe_n_q <= oe_n_d;
      out_q  <= out_d;
      gin_q  <= gin_d;
      hdat_q <= hdat_d;
      addr_q <= addr_d;
      ctl_q  <= ctl_d;
    end
  end

  // Outputs
  assign PIN_OE_N     = oe_n_q;
  assign PIN_OUT      = out_q;
  assign GPIO_IN      = gin_q;
  assign HOST_DATA_IN = hdat_q;
  assign HOST_ADDR    = addr_q;
  assign HOST_SEL     = ctl_q[0];
  assign HOST_ALS     = ctl_q[1];
  assign HOST_RNW     = ctl_q[2];
  assign HOST_RD_STB  = ctl_q[3];
  assign HOST_WR_STB  = ctl_q[4];
  assign HOST_DS      = ctl_q[5];
  assign PORT_MODE    = mode;
endmodule
`default_nettype wire

//--- dv/hpsm_chk_sva.sv
// Checker for the host port signal mux, bound into hpsm_top.
// Assumes one core clock and sees only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module hpsm_chk (
  input wire logic        REF_CLK,      // Core clock
  input wire logic        RESET,        // Reset, active high
  input wire logic [15:0] PORT_CFG,     // Config word
  input wire logic        PORT_CFG_WR,  // Config load
  input wire logic        STOP_STATE,   // Stop state
  input wire logic        HOST_RD_EN,   // Device drives data
  input wire logic [7:0]  HOST_RD_DATA, // Data to host
  input wire logic [15:0] PIN_OUT,      // Pad levels
  input wire logic [15:0] PIN_OE_N,     // Pad enables
  input wire logic [10:0] HOST_ADDR,    // Decoded address
  input wire logic [7:0]  HOST_DATA_IN, // Decoded data
  input wire logic        HOST_SEL,     // Port select
  input wire logic        HOST_ALS,     // Address strobe
  input wire logic        HOST_DS,      // Data strobe
  input wire logic [1:0]  PORT_MODE     // Decoded mode
);
  logic [1:0] mode_exp;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // Mode the config word asks for
  assign mode_exp = {PORT_CFG[1] & PORT_CFG[0], PORT_CFG[0]};
  // ==========================================================================
  // Assertions
  property p_mode; PORT_CFG_WR && !STOP_STATE |=> PORT_MODE == $past(mode_exp);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_frz; STOP_STATE |=> $stable(PORT_MODE); endproperty
  a_frz: assert property (p_frz) else $error("mode moved in stop");
  property p_stop_oe; STOP_STATE [*2] |-> PIN_OE_N == 16'hffff; endproperty
  a_stop_oe: assert property (p_stop_oe) else $error("driven in stop");
  property p_hold;
    STOP_STATE [*4] |-> $stable(HOST_ADDR) && $stable(HOST_DATA_IN);
  endproperty
  a_hold: assert property (p_hold) else $error("input not held");
  property p_quiet;
    (PORT_MODE == 2'b00 && !STOP_STATE) [*5] |->
      !(HOST_SEL | HOST_ALS | HOST_DS);
  endproperty
  a_quiet: assert property (p_quiet) else $error("host out in gpio");
  property p_msel;
    (PORT_MODE == 2'b11 && !STOP_STATE) [*5] |->
      HOST_SEL && HOST_ADDR[2:0] == 3'h0;
  endproperty
  a_msel: assert property (p_msel) else $error("muxed select");
  property p_plain;
    (PORT_MODE == 2'b01 && !STOP_STATE) [*5] |->
      !HOST_ALS && HOST_ADDR[10:3] == 8'h00;
  endproperty
  a_plain: assert property (p_plain) else $error("plain address");
  property p_drv;
    (PORT_MODE != 2'b00 && HOST_RD_EN && !STOP_STATE) [*2] |=>
      PIN_OE_N[7:0] == 8'h00 && PIN_OUT[7:0] == $past(HOST_RD_DATA);
  endproperty
  a_drv: assert property (p_drv) else $error("data not driven");
endmodule
bind hpsm_top hpsm_chk i_hpsm_chk (.REF_CLK, .RESET, .PORT_CFG, .PORT_CFG_WR,
  .STOP_STATE, .HOST_RD_EN, .HOST_RD_DATA, .PIN_OUT, .PIN_OE_N, .HOST_ADDR,
  .HOST_DATA_IN, .HOST_SEL, .HOST_ALS, .HOST_DS, .PORT_MODE);
`default_nettype wire

//--- dv/hpsm_host_model.sv
// Host bus master model: resolves each port pin from both parties.
// Assumes the bench sets what the host drives; no pulls on the pins.
`timescale 1ns/1ps
`default_nettype none
module hpsm_host_model (
  input  wire logic        clk,      // Core clock
  input  wire logic [15:0] pin_out,  // Device pad levels
  input  wire logic [15:0] pin_oe_n, // Device enables, low = driving
  input  wire logic [15:0] host_val, // Levels the host puts out
  input  wire logic [15:0] host_en,  // Pins the host drives
  output logic      [15:0] pin_in    // Resolved pin levels
);
  logic [15:0] float_q = 16'ha5c3;
  // Undriven pins wander every cycle
  always @(posedge clk) float_q <= ~float_q;
  // Device wins where enabled, then host, else the wandering level
  always_comb begin
    pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & host_en & host_val)
           | (pin_oe_n & ~host_en & float_q);
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the host port signal mux.
// Assumes hpsm_pkg, hpsm_pin_if and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cwr = 1'b0, dwr = 1'b0, stop = 1'b0, rde = 1'b0;
  logic [15:0] cfg = 16'h0, dir = 16'h0, gout = 16'h0, hv = 16'h0;
  logic [15:0] hen = 16'hffff, pin_in, pout, oe_n, gin;
  logic [7:0] rdd = 8'h0, din;
  logic [10:0] addr;
  logic sel, als, rnw, rds, wrs, ds;
  logic [1:0] mode;
  logic [31:0] seed = 32'hb7bc, r;
  logic [18:0] prev;
  logic [24:0] ex;
  int errors = 0, cmp_count = 0, cyc = 0;
  hpsm_top i_hpsm_top (.REF_CLK(clk),
    .RESET(rst), .PORT_CFG(cfg), .PORT_CFG_WR(cwr), .GPIO_DIR(dir),
    .GPIO_DIR_WR(dwr), .GPIO_OUT(gout), .STOP_STATE(stop),
    .HOST_RD_DATA(rdd), .HOST_RD_EN(rde), .PIN_IN(pin_in), .PIN_OUT(pout),
    .PIN_OE_N(oe_n), .GPIO_IN(gin), .HOST_DATA_IN(din), .HOST_ADDR(addr),
    .HOST_SEL(sel), .HOST_ALS(als), .HOST_RNW(rnw), .HOST_RD_STB(rds),
    .HOST_WR_STB(wrs), .HOST_DS(ds), .PORT_MODE(mode));
  hpsm_host_model i_hpsm_host_model (.clk(clk), .pin_out(pout),
    .pin_oe_n(oe_n), .host_val(hv), .host_en(hen), .pin_in(pin_in));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // Decoded host outputs expected from config c and pin levels p
  function automatic logic [24:0] exp_host(input logic [15:0] c,
                                           input logic [15:0] p);
    logic m, d;
    m = c[1];
    d = c[2];
    return {m & p[13], m ? p[10:9] : 2'b00, 5'h00, m ? 3'h0 : p[10:8],
      m | (p[13] ~^ c[3]), m & (p[8] ~^ c[4]), !d & p[11],
      d & (p[11] ~^ c[5]), d & (p[12] ~^ c[5]), !d & (p[12] ~^ c[5]), p[7:0]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [15:0] c, input logic [15:0] d);
    cfg = c;
    dir = d;
    cwr = 1'b1;
    dwr = 1'b1;
    step(1);
    cwr = 1'b0;
    dwr = 1'b0;
    step(5);
  endtask
  task automatic do_rst();
    rst = 1'b1;
    step(2);
    chk("rst_oe", 16'hffff, oe_n);
    chk("rst_mode", 2'b00, mode);
    rst = 1'b0;
    hv = 16'(rnd());
    step(5);
    chk("idle_oe", 16'hffff, oe_n);
    chk("idle_in", 24'h0, {gin, din});
  endtask
  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock and run limit
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      give_verdict();
    end
  end
  // Main sequence: gpio, every host mode, stop, reset again
  initial begin
    #1;
    do_rst();
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      gout = r[15:0];
      hv = r[31:16];
      wr(r[15:0] & 16'hfffe, 16'(rnd()));
      chk("g_oe", {~dir}, oe_n);
      chk("g_out", gout & dir, pout & dir);
      chk("g_in", hv & ~dir, gin);
    end
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      rde = 1'b0;
      hen = 16'hffff;
      hv = r[15:0];
      wr({10'h0, r[21:19], k[1:0], 1'b1}, 16'h0);
      chk("mode", {cfg[1], 1'b1}, mode);
      ex = exp_host(cfg, hv);
      chk("addr", ex[24:14], addr);
      chk("sel", ex[13:12], {sel, als});
      chk("strb", ex[11:8], {rnw, rds, wrs, ds});
      chk("din", ex[7:0], din);
      rdd = r[31:24];
      rde = 1'b1;
      hen = 16'hff00;
      step(3);
      chk("drv", {8'h00, rdd}, {oe_n[7:0], pout[7:0]});
    end
    stop = 1'b1;
    step(3);
    chk("stop_oe", 16'hffff, oe_n);
    prev = {addr, din};
    hv = ~hv;
    hen = 16'hffff;
    wr(16'h0000, 16'hffff);
    chk("hold", prev, {addr, din});
    chk("frz", 2'b11, mode);
    stop = 1'b0;
    do_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
